// ===== rtl/cpu_alu_pkg.sv
/*
 * Shared constants and types for the arithmetic/logic execution datapath:
 * operation codes, operand size codes, condition code bit positions,
 * reset values and divider timing.
 * Assumes the instruction decoder outside maps instructions onto op_e and
 * size_e before handing operands to the datapath.
 */
package cpu_alu_pkg;

    // ************************************************************
    // operations
    // ************************************************************
    typedef enum logic [3:0] {
        udiv_equal_width     = 4'h0,
        sdiv_extended        = 4'h1,
        sdiv_equal_width     = 4'h2,
        compare_op           = 4'h3,
        negate_op            = 4'h4,
        zero_extend_op       = 4'h5,
        sign_extend_op       = 4'h6,
        test_and_set_op      = 4'h7,
        accumulate_op        = 4'h8,
        accumulator_clear_op = 4'h9,
        accumulator_load_op  = 4'ha,
        accumulator_store_op = 4'hb,
        and_op               = 4'hc,
        or_op                = 4'hd,
        xor_op               = 4'he,
        not_op               = 4'hf
    } op_e;

    // ************************************************************
    // operand sizes
    // ************************************************************
    typedef enum logic [1:0] {
        SIZE_BYTE = 2'h0,
        SIZE_WORD = 2'h1,
        SIZE_LONG = 2'h2
    } size_e;

    localparam logic [31:0] MASK_BYTE  = 32'h0000_00ff;
    localparam logic [31:0] MASK_WORD  = 32'h0000_ffff;
    localparam logic [31:0] MASK_LONG  = 32'hffff_ffff;
    localparam int          ALIGN_BYTE = 24;
    localparam int          ALIGN_WORD = 16;

    // ************************************************************
    // condition code register layout and reset values
    // ************************************************************
    localparam int          CCR_N     = 3;
    localparam int          CCR_Z     = 2;
    localparam int          CCR_V     = 1;
    localparam int          CCR_C     = 0;
    localparam logic [3:0]  CCR_RESET = 4'h0;
    localparam logic [31:0] ACC_RESET = 32'h0000_0000;
    localparam logic [7:0]  TAS_SET   = 8'h80;

    // ************************************************************
    // divider timing
    // ************************************************************
    localparam logic [5:0]  DIV_LAST_STEP = 6'h1f;

    typedef enum logic [0:0] {
        st_idle   = 1'b0,
        st_divide = 1'b1
    } fsm_e;

endpackage

// ===== rtl/div_core.sv
/*
 * Unsigned 32 by 32 restoring divider, one quotient bit per clock.
 * Assumes the caller reduces signed or narrow divides to unsigned 32-bit
 * magnitudes and holds off a new start until done_o has pulsed.
 */
`timescale 1ns/10ps
module div_core
    import cpu_alu_pkg::*;
(
    input  wire logic        core_clk_i,  // cpu clock
    input  wire logic        rstn_i,      // sync reset, active low
    input  wire logic        start_i,     // one-cycle start pulse
    input  wire logic [31:0] dividend_i,  // unsigned dividend
    input  wire logic [31:0] divisor_i,   // unsigned divisor
    output logic             done_o,      // one-cycle result pulse
    output logic      [31:0] quot_o,      // quotient
    output logic      [31:0] rem_o        // remainder
);

    typedef struct packed {
        logic        active;
        logic        done;
        logic [5:0]  cnt;
        logic [31:0] rem;
        logic [31:0] quot;
        logic [31:0] divisor;
    } div_s;

    div_s        r;
    div_s        next_r;
    logic [32:0] shifted;
    logic [32:0] trial;

    always_comb begin
        next_r  = r;
        shifted = {r.rem, r.quot[31]};
        trial   = shifted - {1'b0, r.divisor};
        next_r.done = 1'b0;
        if (start_i) begin
            next_r.active  = 1'b1;
            next_r.cnt     = 6'h00;
            next_r.rem     = 32'h0000_0000;
            next_r.quot    = dividend_i;
            next_r.divisor = divisor_i;
        end else if (r.active) begin
            // zero divisor falls out as an all-ones quotient
            if (!trial[32]) begin
                next_r.rem  = trial[31:0];
                next_r.quot = {r.quot[30:0], 1'b1};
            end else begin
                next_r.rem  = shifted[31:0];
                next_r.quot = {r.quot[30:0], 1'b0};
            end
            next_r.cnt = r.cnt + 6'h01;
            if (r.cnt == DIV_LAST_STEP) begin
                next_r.active = 1'b0;
                next_r.done   = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign done_o = r.done;
    assign quot_o = r.quot;
    assign rem_o  = r.rem;

endmodule

// ===== rtl/cpu_arith_logic_ops.sv
/*
 * Execution datapath for divide, compare, negate, extend, test-and-set,
 * multiply-accumulate and bitwise operations of a 32-bit cpu.
 * Assumes the decoder supplies operands already fetched from registers,
 * immediates or memory, and writes result_o back where the op says.
 */
`timescale 1ns/10ps
module cpu_arith_logic_ops
    import cpu_alu_pkg::*;
(
    input  wire logic        core_clk_i,      // cpu clock, 125 MHz
    input  wire logic        rstn_i,          // sync reset, active low
    input  wire logic        op_valid_i,      // operation request
    input  wire op_e         op_i,            // operation code
    input  wire size_e       size_i,          // operand size
    input  wire logic        ext_from_word_i, // extend from low 16 bits
    input  wire logic [31:0] dst_i,           // destination operand
    input  wire logic [31:0] src_i,           // source operand
    output logic             busy_o,          // divide in progress
    output logic             done_o,          // operation finished
    output logic      [31:0] result_o,        // value to write back
    output logic             result_we_o,     // write result_o back
    output logic      [3:0]  ccr_o,           // condition codes NZVC
    output logic             ccr_we_o,        // condition codes updated
    output logic      [31:0] acc_o            // accumulator contents
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] size_mask(input size_e sz);
        case (sz)
            SIZE_BYTE: size_mask = MASK_BYTE;
            SIZE_WORD: size_mask = MASK_WORD;
            default:   size_mask = MASK_LONG;
        endcase
    endfunction

    // move the operand msb to bit 31 so one flag path serves all sizes
    function automatic logic [31:0] align_msb(input logic [31:0] v,
                                              input size_e       sz);
        case (sz)
            SIZE_BYTE: align_msb = v << ALIGN_BYTE;
            SIZE_WORD: align_msb = v << ALIGN_WORD;
            default:   align_msb = v;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] res,
                                          input size_e       sz);
        logic [31:0] m;
        m     = size_mask(sz);
        merge = (old & ~m) | (res & m);
    endfunction

    // negative and zero of a value at the given size
    function automatic logic [1:0] nz(input logic [31:0] v,
                                      input size_e       sz);
        logic [31:0] a;
        a  = align_msb(v, sz);
        nz = {a[31], a == 32'h0000_0000};
    endfunction

    // NZVC of a minus b, both already msb-aligned
    function automatic logic [3:0] sub_flags(input logic [31:0] a,
                                             input logic [31:0] b);
        logic [32:0] d;
        d = {1'b0, a} - {1'b0, b};
        sub_flags = {d[31], d[31:0] == 32'h0000_0000,
                     (a[31] ^ b[31]) & (a[31] ^ d[31]), d[32]};
    endfunction

    function automatic logic [3:0] logic_flags(input logic [31:0] v,
                                               input size_e       sz,
                                               input logic [3:0]  old);
        logic [1:0] f;
        f = nz(v, sz);
        logic_flags = old;
        logic_flags[CCR_N] = f[1];
        logic_flags[CCR_Z] = f[0];
        logic_flags[CCR_V] = 1'b0;
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        fsm_e        fsm;
        op_e         op;
        size_e       size;
        logic [31:0] dst;
        logic        neg_q;
        logic        neg_r;
        logic        div_start;
        logic [31:0] dividend;
        logic [31:0] divisor;
        logic [31:0] result;
        logic        result_we;
        logic [3:0]  condition_code_register;
        logic        ccr_we;
        logic [31:0] acc;
        logic        done;
        logic        busy;
    } state_s;

    state_s      r;
    state_s      next_r;
    logic        div_done;
    logic [31:0] div_quot;
    logic [31:0] div_rem;
    logic [31:0] dvd;
    logic [31:0] dvs;
    logic        sgn;
    logic [31:0] qv;
    logic [31:0] rv;
    logic [31:0] ext_val;
    logic [31:0] prod;
    logic [31:0] lres;

    div_core u_div (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .start_i    (r.div_start),
        .dividend_i (r.dividend),
        .divisor_i  (r.divisor),
        .done_o     (div_done),
        .quot_o     (div_quot),
        .rem_o      (div_rem)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_r  = r;
        dvd     = dst_i;
        dvs     = src_i;
        sgn     = 1'b0;
        qv      = r.neg_q ? 32'h0000_0000 - div_quot : div_quot;
        rv      = r.neg_r ? 32'h0000_0000 - div_rem : div_rem;
        ext_val = 32'h0000_0000;
        // low 32 bits of the sign-extended product equal the signed one
        prod    = {{16{dst_i[15]}}, dst_i[15:0]}
                  * {{16{src_i[15]}}, src_i[15:0]};
        lres    = 32'h0000_0000;
        next_r.done      = 1'b0;
        next_r.result_we = 1'b0;
        next_r.ccr_we    = 1'b0;
        next_r.div_start = 1'b0;
        case (r.fsm)
            st_idle: begin
                if (op_valid_i) begin
                    next_r.op   = op_i;
                    next_r.size = size_i;
                    next_r.dst  = dst_i;
                    next_r.done = 1'b1;
                    case (op_i)
                        udiv_equal_width, sdiv_extended,
                        sdiv_equal_width: begin
                            // widen both operands to 32-bit values
                            case (op_i)
                                udiv_equal_width: begin
                                    dvd = dst_i & size_mask(size_i);
                                    dvs = src_i & size_mask(size_i);
                                end
                                sdiv_extended: begin
                                    sgn = 1'b1;
                                    if (size_i == SIZE_BYTE) begin
                                        dvd = {{16{dst_i[15]}}, dst_i[15:0]};
                                        dvs = {{24{src_i[7]}}, src_i[7:0]};
                                    end else begin
                                        dvs = {{16{src_i[15]}}, src_i[15:0]};
                                    end
                                end
                                default: begin
                                    sgn = 1'b1;
                                    if (size_i == SIZE_WORD) begin
                                        dvd = {{16{dst_i[15]}}, dst_i[15:0]};
                                        dvs = {{16{src_i[15]}}, src_i[15:0]};
                                    end
                                end
                            endcase
                            next_r.neg_q    = sgn & (dvd[31] ^ dvs[31]);
                            next_r.neg_r    = sgn & dvd[31];
                            next_r.dividend = (sgn & dvd[31]) ?
                                              32'h0000_0000 - dvd : dvd;
                            next_r.divisor  = (sgn & dvs[31]) ?
                                              32'h0000_0000 - dvs : dvs;
                            next_r.div_start = 1'b1;
                            next_r.fsm       = st_divide;
                            next_r.busy      = 1'b1;
                            next_r.done      = 1'b0;
                        end
                        compare_op: begin
                            next_r.condition_code_register = sub_flags(align_msb(dst_i, size_i),
                                align_msb(src_i, size_i));
                            next_r.ccr_we = 1'b1;
                        end
                        negate_op: begin
                            next_r.result = merge(dst_i,
                                32'h0000_0000 - dst_i, size_i);
                            next_r.condition_code_register = sub_flags(32'h0000_0000,
                                                   align_msb(dst_i, size_i));
                            next_r.result_we = 1'b1;
                            next_r.ccr_we    = 1'b1;
                        end
                        zero_extend_op, sign_extend_op: begin
                            if (size_i == SIZE_LONG && ext_from_word_i) begin
                                ext_val = (op_i == sign_extend_op) ?
                                    {{16{dst_i[15]}}, dst_i[15:0]} :
                                    {16'h0000, dst_i[15:0]};
                            end else begin
                                ext_val = (op_i == sign_extend_op) ?
                                    {{24{dst_i[7]}}, dst_i[7:0]} :
                                    {24'h00_0000, dst_i[7:0]};
                            end
                            next_r.result = merge(dst_i, ext_val, size_i);
                            next_r.condition_code_register = logic_flags(ext_val, size_i, r.condition_code_register);
                            next_r.result_we = 1'b1;
                            next_r.ccr_we    = 1'b1;
                        end
                        test_and_set_op: begin
                            // flags reflect the byte before bit 7 is set
                            next_r.condition_code_register = logic_flags(dst_i, SIZE_BYTE,
                                                     r.condition_code_register);
                            next_r.condition_code_register[CCR_C] = 1'b0;
                            next_r.result = merge(dst_i,
                                {24'h00_0000, dst_i[7:0] | TAS_SET},
                                SIZE_BYTE);
                            next_r.result_we = 1'b1;
                            next_r.ccr_we    = 1'b1;
                        end
                        accumulate_op: begin
                            next_r.acc = r.acc + prod;
                        end
                        accumulator_clear_op: begin
                            next_r.acc = ACC_RESET;
                        end
                        accumulator_load_op: begin
                            next_r.acc = src_i;
                        end
                        accumulator_store_op: begin
                            next_r.result    = r.acc;
                            next_r.result_we = 1'b1;
                        end
                        and_op, or_op, xor_op, not_op: begin
                            case (op_i)
                                and_op:  lres = dst_i & src_i;
                                or_op:   lres = dst_i | src_i;
                                xor_op:  lres = dst_i ^ src_i;
                                default: lres = ~dst_i;
                            endcase
                            next_r.result = merge(dst_i, lres, size_i);
                            next_r.condition_code_register = logic_flags(lres, size_i, r.condition_code_register);
                            next_r.result_we = 1'b1;
                            next_r.ccr_we    = 1'b1;
                        end
                        default: begin
                            next_r.done = 1'b1;
                        end
                    endcase
                end
            end
            st_divide: begin
                if (div_done) begin
                    next_r.fsm       = st_idle;
                    next_r.busy      = 1'b0;
                    next_r.done      = 1'b1;
                    next_r.result_we = 1'b1;
                    next_r.ccr_we    = 1'b1;
                    if (r.op == sdiv_extended) begin
                        // remainder above quotient, each half the width
                        if (r.size == SIZE_BYTE) begin
                            next_r.result = merge(r.dst,
                                {16'h0000, rv[7:0], qv[7:0]}, SIZE_WORD);
                            next_r.condition_code_register = logic_flags(qv, SIZE_BYTE, r.condition_code_register);
                        end else begin
                            next_r.result = {rv[15:0], qv[15:0]};
                            next_r.condition_code_register = logic_flags(qv, SIZE_WORD, r.condition_code_register);
                        end
                    end else begin
                        next_r.result = merge(r.dst, qv, r.size);
                        next_r.condition_code_register = logic_flags(qv, r.size, r.condition_code_register);
                    end
                end
            end
            default: begin
                next_r.fsm  = st_idle;
                next_r.busy = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            r     <= '0;
            r.fsm <= st_idle;
            r.condition_code_register <= CCR_RESET;
            r.acc <= ACC_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign busy_o      = r.busy;
    assign done_o      = r.done;
    assign result_o    = r.result;
    assign result_we_o = r.result_we;
    assign ccr_o       = r.condition_code_register;
    assign ccr_we_o    = r.ccr_we;
    assign acc_o       = r.acc;

endmodule

// ===== test/cpu_alu_assertions.sv
/* port checker for the arithmetic/logic execution datapath.
   assumes it is bound onto cpu_arith_logic_ops, one clock domain. */
`timescale 1ns/10ps
module cpu_alu_checker
    import cpu_alu_pkg::*;
(
    input  wire logic        core_clk_i,      // cpu clock
    input  wire logic        rstn_i,          // sync reset, low
    input  wire logic        op_valid_i,      // request
    input  wire op_e         op_i,            // operation
    input  wire size_e       size_i,          // operand size
    input  wire logic        ext_from_word_i, // extend from 16
    input  wire logic [31:0] dst_i,           // destination
    input  wire logic [31:0] src_i,           // source
    input  wire logic        busy_o,          // divide running
    input  wire logic        done_o,          // finished
    input  wire logic [31:0] result_o,        // write-back value
    input  wire logic        result_we_o,     // write-back strobe
    input  wire logic [3:0]  ccr_o,           // flags
    input  wire logic        ccr_we_o,        // flag strobe
    input  wire logic [31:0] acc_o            // accumulator
);
    logic [31:0] dst_q;
    logic        take;
    logic        is_div;
    assign take   = op_valid_i && !busy_o;
    assign is_div = op_i inside {udiv_equal_width, sdiv_extended,
                                 sdiv_equal_width};
    // operands need not be held, so keep the taken copy
    always_ff @(posedge core_clk_i) begin
        dst_q <= dst_i;
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    property p_div_time;
        take && is_div |=> busy_o ##33 busy_o ##1 (done_o && !busy_o);
    endproperty
    a_div_time: assert property (p_div_time)
        else $error("divide not finished 35 cycles after start");
    property p_fast;
        take && !is_div |=> done_o && !busy_o;
    endproperty
    a_fast: assert property (p_fast)
        else $error("single-cycle op did not finish");
    property p_cmp;
        take && op_i == compare_op |=>
            ccr_we_o && !result_we_o && $stable(result_o);
    endproperty
    a_cmp: assert property (p_cmp)
        else $error("compare touched the result");
    property p_neg;
        take && op_i == negate_op && size_i == SIZE_LONG |=>
            result_o == 32'h0 - dst_q;
    endproperty
    a_neg: assert property (p_neg)
        else $error("negate result wrong");
    property p_not;
        take && op_i == not_op && size_i == SIZE_BYTE |=>
            result_o == {dst_q[31:8], ~dst_q[7:0]};
    endproperty
    a_not: assert property (p_not)
        else $error("invert result wrong");
    property p_zext;
        take && op_i == zero_extend_op && size_i == SIZE_LONG
            && ext_from_word_i |=> result_o == {16'h0, dst_q[15:0]};
    endproperty
    a_zext: assert property (p_zext)
        else $error("zero extend result wrong");
    property p_sext;
        take && op_i == sign_extend_op && size_i == SIZE_LONG
            && !ext_from_word_i |=> result_o == {{24{dst_q[7]}}, dst_q[7:0]};
    endproperty
    a_sext: assert property (p_sext)
        else $error("sign extend result wrong");
    property p_tas;
        take && op_i == test_and_set_op |=>
            result_o[7:0] == (dst_q[7:0] | TAS_SET)
            && ccr_o[CCR_Z] == (dst_q[7:0] == 8'h0);
    endproperty
    a_tas: assert property (p_tas)
        else $error("test and set wrong");
    property p_clr;
        take && op_i == accumulator_clear_op |=> acc_o == ACC_RESET;
    endproperty
    a_clr: assert property (p_clr)
        else $error("accumulator not cleared");
    property p_store;
        take && op_i == accumulator_store_op |=>
            result_we_o && result_o == acc_o && $stable(acc_o);
    endproperty
    a_store: assert property (p_store)
        else $error("accumulator store wrong");
    c_div: cover property (take && is_div);
    c_cmp: cover property (take && op_i == compare_op);
    c_mac: cover property (take && op_i == accumulate_op);
endmodule

bind cpu_arith_logic_ops cpu_alu_checker u_cpu_alu_checker (
    .core_clk_i, .rstn_i, .op_valid_i, .op_i, .size_i, .ext_from_word_i,
    .dst_i, .src_i, .busy_o, .done_o, .result_o, .result_we_o, .ccr_o,
    .ccr_we_o, .acc_o);

// ===== test/tb.sv
/* self-checking bench for cpu_arith_logic_ops, one task per scenario.
   assumes dst_i carries the dividend and src_i the divisor. */
`timescale 1ns/10ps
module tb
    import cpu_alu_pkg::*;
;
    logic        core_clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        op_valid_i = 1'b0;
    op_e         op_i = and_op;
    size_e       size_i = SIZE_BYTE;
    logic        ext_from_word_i = 1'b0;
    logic [31:0] dst_i = 32'h0;
    logic [31:0] src_i = 32'h0;
    logic        busy_o, done_o, result_we_o, ccr_we_o;
    logic [31:0] result_o, acc_o;
    logic [3:0]  ccr_o;
    int          fail_count = 0;
    int          n_tests = 0;
    int          cyc = 0;

    always #4 core_clk_i = ~core_clk_i;

    cpu_arith_logic_ops u_cpu_arith_logic_ops (
        .core_clk_i, .rstn_i, .op_valid_i, .op_i, .size_i,
        .ext_from_word_i, .dst_i, .src_i, .busy_o, .done_o, .result_o,
        .result_we_o, .ccr_o, .ccr_we_o, .acc_o);

    // ********
    // helpers
    // ********
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // garbles dst_i after the taking edge, operands need not be held
    task automatic run(input op_e o, input size_e s, input logic w,
                       input logic [31:0] d, input logic [31:0] r);
        int n = 0;
        @(posedge core_clk_i);
        op_i <= o;
        size_i <= s;
        ext_from_word_i <= w;
        dst_i <= d;
        src_i <= r;
        op_valid_i <= 1'b1;
        @(posedge core_clk_i);
        op_valid_i <= 1'b0;
        dst_i <= ~d;
        #1;
        while (done_o !== 1'b1 && n < 40) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        chk("done", 32'h1, {31'h0, done_o});
    endtask

    task automatic rc(input op_e o, input size_e s, input logic w,
                      input logic [31:0] d, input logic [31:0] r,
                      input logic [31:0] exp);
        run(o, s, w, d, r);
        chk("result", exp, result_o);
    endtask

    // ********
    // scenarios
    // ********
    task automatic t_div;
        rc(udiv_equal_width, SIZE_LONG, 0, 32'd100000, 7,
           32'h0000_37cd);
        rc(udiv_equal_width, SIZE_WORD, 0, 32'habcd_0064, 32'h1234_0007,
           32'habcd_000e);
        rc(sdiv_extended, SIZE_BYTE, 0, 32'h5555_ff9c, 7,
           32'h5555_fef2);
        rc(sdiv_extended, SIZE_WORD, 0, 32'd1000, 32'h0000_fffd,
           32'h0001_feb3);
        rc(sdiv_equal_width, SIZE_LONG, 0, 32'hffff_fc18, 7,
           32'hffff_ff72);
    endtask

    task automatic t_cmp;
        rc(and_op, SIZE_LONG, 0, 32'hffff_ffff, 32'h1234_5678,
           32'h1234_5678);
        rc(compare_op, SIZE_BYTE, 0, 32'h0000_0005, 5,
           32'h1234_5678);
        chk("ccr", 32'h4, {28'h0, ccr_o});
        chk("we", 32'h0, {31'h0, result_we_o});
        run(compare_op, SIZE_BYTE, 0, 32'h3, 32'h5);
        chk("ccr", 32'h9, {28'h0, ccr_o});
        rc(test_and_set_op, SIZE_BYTE, 0, 32'h0, 0,
           32'h0000_0080);
        chk("ccr", 32'h4, {28'h0, ccr_o});
    endtask

    task automatic t_unary;
        rc(negate_op, SIZE_LONG, 0, 32'h1, 0, 32'hffff_ffff);
        rc(negate_op, SIZE_WORD, 0, 32'h1234_0001, 0,
           32'h1234_ffff);
        rc(zero_extend_op, SIZE_LONG, 1, 32'hdead_8123, 0,
           32'h0000_8123);
        rc(zero_extend_op, SIZE_WORD, 0, 32'hdead_8183, 0,
           32'hdead_0083);
        rc(sign_extend_op, SIZE_LONG, 0, 32'h1234_5680, 0,
           32'hffff_ff80);
        rc(sign_extend_op, SIZE_WORD, 0, 32'h0000_0080, 0,
           32'h0000_ff80);
    endtask

    task automatic t_logic;
        logic [31:0] d = 32'hf0f0_3c3c;
        logic [31:0] r = 32'h0ff0_aa55;
        logic [31:0] m, v;
        op_e         o;
        for (int s = 0; s < 3; s++) begin
            m = s == 0 ? MASK_BYTE : s == 1 ? MASK_WORD : MASK_LONG;
            for (int k = 0; k < 4; k++) begin
                o = op_e'(and_op + k);
                v = o == and_op ? d & r : o == or_op ? d | r :
                    o == xor_op ? d ^ r : ~d;
                rc(o, size_e'(s), 0, d, r, (d & ~m) | (v & m));
            end
        end
    endtask

    task automatic t_mac;
        run(accumulator_clear_op, SIZE_LONG, 0, 0, 0);
        chk("acc", 32'h0, acc_o);
        run(accumulator_load_op, SIZE_LONG, 0, 0, 32'h10);
        chk("acc", 32'h10, acc_o);
        // both negative, product needs more than 16 bits
        run(accumulate_op, SIZE_LONG, 0, 32'h7777_fffe,
            32'h8888_8000);
        chk("acc", 32'h0001_0010, acc_o);
        rc(accumulator_store_op, SIZE_BYTE, 0, 32'hffff_ffff, 0,
           32'h0001_0010);
        chk("acc", 32'h0001_0010, acc_o);
    endtask

    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc > 3000) begin
            fail_count++;
            wrap_up;
        end
    end

    initial begin
        repeat (12) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        #1;
        chk("acc", 32'h0, acc_o);
        chk("ccr", 32'h0, {28'h0, ccr_o});
        t_div;
        t_cmp;
        t_unary;
        t_logic;
        t_mac;
        wrap_up;
    end
endmodule
